// >>> hw/ram_fifo_pointer_set_control.sv
// APB register front end and four pointer sets of the RAM-backed FIFO
// Functional notes
// R1 - Temp pointer is 11 bits, upper bits zero
// R2 - Read temp mode: mark copies, load restores read
// R3 - Write temp mode: mark copies, load restores write
// R4 - Valid byte count readable, upper bits zero
// R5 - Free byte count readable, upper bits zero
// R6 - Read start address is base plus read
// R7 - Write start address is base plus write
// R8 - Per-set control register, reset value 0x06
// R9 - Bit 7 enables first transfer ID
// R10 - Bit 6 enables second transfer ID
// R11 - Bits 5:4 select temp pointer role
// R12 - Bit 3 selects byte or word transfers
// R13 - Size field selects capacity; 111 no boundary
// R14 - Software zeroes base bits below boundary
// R15 - Pointer bits above boundary ignored, no carry
// R16 - Window shows item latched by view select
// R17 - Pointers advance per access, wrap to zero
// R18 - Base is 16 bits at window 19:4
// R19 - Valid is write minus read; free remainder
// R20 - No boundary behaves as 2048-byte setting
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ram_fifo_pointer_set_control
  import ram_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_rd_req,
  input wire logic acc_wr_req,
  input wire logic [1:0] acc_set,
  output logic [31:0] ram_read_addr,
  output logic [31:0] ram_write_addr,
  output logic [NUM_SETS-1:0] first_id_enable,
  output logic [NUM_SETS-1:0] second_id_enable,
  output logic [NUM_SETS-1:0] word_transfer
);

  typedef struct packed {
    logic [NUM_SETS-1:0][7:0] ctrl;
    logic [1:0] view_set;
    logic [2:0] view_item;
    logic [31:0] window;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [31:0] rd_addr;
    logic [31:0] wr_addr;
  } main_state_s;

  main_state_s state_reg;
  main_state_s state_next;
  set_cmd_s cmd [NUM_SETS];
  set_status_s stat [NUM_SETS];
  logic access;
  logic commit;
  logic is_ctrl;
  logic mapped;
  logic [1:0] ctrl_idx;
  logic [1:0] wsel_set;
  logic [2:0] wsel_item;
  logic [1:0] cmd_set;
  set_status_s vs;
  logic [31:0] item_value;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer sets
  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_set
      pointer_set u_set (
        .pclk(pclk),
        .presetn(presetn),
        .ctrl(state_reg.ctrl[g]),
        .cmd(cmd[g]),
        .status(stat[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    access = psel && penable && !state_reg.ready;
    commit = psel && penable && state_reg.ready;
    is_ctrl = (paddr >= CTRL0_OFS) && (paddr <= CTRL3_OFS)
              && (paddr[1:0] == 2'h0);
    ctrl_idx = 2'((paddr - CTRL0_OFS) >> 2);
    mapped = is_ctrl || (paddr == WINDOW_OFS) || (paddr == VIEW_OFS)
             || (paddr == CMD_OFS);
    wsel_set = pwdata[SET_HI_BIT:SET_LO_BIT];
    wsel_item = pwdata[ITEM_HI_BIT:0];
    cmd_set = pwdata[SET_HI_BIT:SET_LO_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Item selected by a view select write, captured at that write
  always_comb begin
    vs = stat[wsel_set];
    case (wsel_item)
      ITEM_BASE: item_value = {BASE_UPPER_ONES, vs.base, 4'h0}; // R18
      ITEM_READ_PTR: item_value = {21'h000000, vs.read_pointer};
      ITEM_WRITE_PTR: item_value = {21'h000000, vs.write_pointer};
      ITEM_TEMP: item_value = {21'h000000, vs.temp_pointer}; // R1
      ITEM_VALID: item_value = {21'h000000, vs.valid_byte_count}; // R4
      ITEM_FREE: item_value = {21'h000000, vs.free_byte_count}; // R5
      ITEM_READ_START: item_value = vs.read_start_address; // R6
      ITEM_WRITE_START: item_value = vs.write_start_address; // R7
      default: item_value = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer set commands
  always_comb begin
    for (int i = 0; i < NUM_SETS; i++) begin
      cmd[i] = '0;
      cmd[i].wr_data = pwdata;
      cmd[i].wr_item = state_reg.view_item[1:0];
      cmd[i].rd_adv = acc_rd_req && (acc_set == 2'(i)); // R17
      cmd[i].wr_adv = acc_wr_req && (acc_set == 2'(i)); // R17
      if (commit && pwrite) begin
        if (paddr == WINDOW_OFS && state_reg.view_set == 2'(i)
            && !state_reg.view_item[2]) begin
          cmd[i].wr_en = 1'b1; // R16
        end
        if (paddr == CMD_OFS && cmd_set == 2'(i)) begin
          cmd[i].load = pwdata[LOAD_BIT]; // R2 R3
          cmd[i].mark = pwdata[MARK_BIT]; // R2 R3
          cmd[i].clear = pwdata[CLEAR_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and APB answer
  always_comb begin
    state_next = state_reg;
    state_next.ready = access;
    state_next.rd_addr = stat[acc_set].read_start_address;
    state_next.wr_addr = stat[acc_set].write_start_address;
    if (access) begin
      state_next.slverr = !mapped;
      state_next.rdata = '0;
      if (!pwrite) begin
        if (paddr == WINDOW_OFS) begin
          state_next.rdata = state_reg.window; // R16
        end else if (paddr == VIEW_OFS) begin
          state_next.rdata = {26'h0000000, state_reg.view_set, 1'b0,
                              state_reg.view_item};
        end else if (is_ctrl) begin
          state_next.rdata = {24'h000000, state_reg.ctrl[ctrl_idx]};
        end
      end
    end else begin
      state_next.slverr = 1'b0;
    end
    if (commit && pwrite) begin
      if (is_ctrl) begin
        state_next.ctrl[ctrl_idx] = pwdata[7:0]; // R8 R11 R13
      end
      if (paddr == VIEW_OFS) begin
        state_next.view_set = wsel_set;
        state_next.view_item = wsel_item;
        state_next.window = item_value; // R16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.ctrl <= {NUM_SETS{CTRL_RESET}}; // R8
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    prdata = state_reg.rdata;
    pready = state_reg.ready;
    pslverr = state_reg.slverr;
    ram_read_addr = state_reg.rd_addr;
    ram_write_addr = state_reg.wr_addr;
    for (int i = 0; i < NUM_SETS; i++) begin
      first_id_enable[i] = state_reg.ctrl[i][FIRST_ID_BIT]; // R9
      second_id_enable[i] = state_reg.ctrl[i][SECOND_ID_BIT]; // R10
      word_transfer[i] = state_reg.ctrl[i][XFER_SIZE_BIT]; // R12
    end
  end

endmodule // ram_fifo_pointer_set_control
`default_nettype wire

// >>> hw/ram_fifo_pkg.sv
// Package: register map, field layout and carrier types of the FIFO pointer sets
package ram_fifo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_SETS = 4;
  localparam int PTR_W = 11;
  localparam int BASE_W = 16;
  localparam int ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] WINDOW_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] VIEW_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CTRL0_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] CTRL3_OFS = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields and reset value
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam int FIRST_ID_BIT = 7;
  localparam int SECOND_ID_BIT = 6;
  localparam int MODE_HI_BIT = 5;
  localparam int MODE_LO_BIT = 4;
  localparam int XFER_SIZE_BIT = 3;
  localparam int BOUND_HI_BIT = 2;
  localparam logic [1:0] MODE_WRITE_TEMP = 2'h2;
  localparam logic [1:0] MODE_READ_TEMP = 2'h3;
  localparam logic [2:0] BOUND_NONE = 3'h7;
  localparam logic [2:0] BOUND_MAX = 3'h6;
  localparam logic [11:0] MIN_FIFO_BYTES = 12'h020;

  ////////////////////////////////////////////////////////////////////////////
  // View select and command register fields
  localparam int ITEM_HI_BIT = 2;
  localparam int SET_HI_BIT = 5;
  localparam int SET_LO_BIT = 4;
  localparam int LOAD_BIT = 3;
  localparam int MARK_BIT = 2;
  localparam int CLEAR_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Window items
  localparam logic [2:0] ITEM_BASE = 3'h0;
  localparam logic [2:0] ITEM_READ_PTR = 3'h1;
  localparam logic [2:0] ITEM_WRITE_PTR = 3'h2;
  localparam logic [2:0] ITEM_TEMP = 3'h3;
  localparam logic [2:0] ITEM_VALID = 3'h4;
  localparam logic [2:0] ITEM_FREE = 3'h5;
  localparam logic [2:0] ITEM_READ_START = 3'h6;
  localparam logic [2:0] ITEM_WRITE_START = 3'h7;
  localparam logic [11:0] BASE_UPPER_ONES = 12'hFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic wr_en;
    logic [1:0] wr_item;
    logic [31:0] wr_data;
    logic load;
    logic mark;
    logic clear;
    logic rd_adv;
    logic wr_adv;
  } set_cmd_s;

  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [PTR_W-1:0] read_pointer;
    logic [PTR_W-1:0] write_pointer;
    logic [PTR_W-1:0] temp_pointer;
    logic [PTR_W-1:0] valid_byte_count;
    logic [PTR_W-1:0] free_byte_count;
    logic [31:0] read_start_address;
    logic [31:0] write_start_address;
  } set_status_s;

endpackage

// >>> hw/pointer_set.sv
// One pointer set: base, read, write and temporary pointers with derived status
`timescale 1ns/1ps
`default_nettype none
module pointer_set
  import ram_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] ctrl,
  input wire set_cmd_s cmd,
  output set_status_s status
);

  typedef struct packed {
    logic [BASE_W-1:0] base;
    logic [PTR_W-1:0] read_pointer;
    logic [PTR_W-1:0] write_pointer;
    logic [PTR_W-1:0] temp_pointer;
  } set_state_s;

  set_state_s state_reg;
  set_state_s state_next;
  logic [2:0] bound;
  logic [11:0] fifo_bytes;
  logic [PTR_W-1:0] mask;
  logic [PTR_W-1:0] step;
  logic [PTR_W-1:0] wdata;
  logic [1:0] mode;
  logic [11:0] free_full;

  ////////////////////////////////////////////////////////////////////////////
  // Boundary decode
  always_comb begin
    bound = (ctrl[BOUND_HI_BIT:0] == BOUND_NONE) ? BOUND_MAX
                                                 : ctrl[BOUND_HI_BIT:0]; // R20
    fifo_bytes = MIN_FIFO_BYTES << bound; // R13
    mask = 11'(fifo_bytes - 12'h001); // R15
    step = ctrl[XFER_SIZE_BIT] ? 11'h002 : 11'h001; // R12
    wdata = cmd.wr_data[PTR_W-1:0] & mask; // R15
    mode = ctrl[MODE_HI_BIT:MODE_LO_BIT]; // R11
  end

  function automatic logic [PTR_W-1:0] advance(input logic [PTR_W-1:0] p,
      input logic [PTR_W-1:0] n, input logic [11:0] lim);
    logic [11:0] sum;
    sum = {1'b0, p} + {1'b0, n};
    advance = (sum >= lim) ? '0 : sum[PTR_W-1:0]; // R17
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    if (cmd.rd_adv) begin
      state_next.read_pointer = advance(state_reg.read_pointer, step,
                                        fifo_bytes); // R17
    end
    if (cmd.wr_adv) begin
      state_next.write_pointer = advance(state_reg.write_pointer, step,
                                         fifo_bytes); // R17
    end
    if (cmd.clear) begin
      state_next.read_pointer = '0;
      state_next.write_pointer = '0;
      state_next.temp_pointer = '0;
    end else if (cmd.load) begin
      if (mode == MODE_READ_TEMP) begin
        state_next.read_pointer = state_reg.temp_pointer; // R2
      end else if (mode == MODE_WRITE_TEMP) begin
        state_next.write_pointer = state_reg.temp_pointer; // R3
      end
    end else if (cmd.mark) begin
      if (mode == MODE_READ_TEMP) begin
        state_next.temp_pointer = state_reg.read_pointer; // R2
      end else if (mode == MODE_WRITE_TEMP) begin
        state_next.temp_pointer = state_reg.write_pointer; // R3
      end
    end
    if (cmd.wr_en) begin
      case (cmd.wr_item)
        2'h0: state_next.base = cmd.wr_data[19:4]; // R18
        2'h1: state_next.read_pointer = wdata;
        2'h2: state_next.write_pointer = wdata;
        2'h3: state_next.temp_pointer = wdata; // R1
        default: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status
  always_comb begin
    status.base = state_reg.base;
    status.read_pointer = state_reg.read_pointer;
    status.write_pointer = state_reg.write_pointer;
    status.temp_pointer = state_reg.temp_pointer;
    status.valid_byte_count = (state_reg.write_pointer
                               - state_reg.read_pointer) & mask; // R19
    free_full = fifo_bytes - {1'b0, status.valid_byte_count}; // R19
    status.free_byte_count = free_full[11] ? 11'h7FF : free_full[PTR_W-1:0];
    status.read_start_address = {BASE_UPPER_ONES, state_reg.base, 4'h0}
                                + {21'h000000, state_reg.read_pointer}; // R6
    status.write_start_address = {BASE_UPPER_ONES, state_reg.base, 4'h0}
                                 + {21'h000000, state_reg.write_pointer}; // R7
  end

endmodule // pointer_set
`default_nettype wire

// >>> verification/ram_fifo_chk.sv
// Checker: bus timing, control outputs and pointer step assertions
`timescale 1ns/1ps
`default_nettype none
module ram_fifo_chk
  import ram_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic acc_rd_req,
  input wire logic acc_wr_req,
  input wire logic [1:0] acc_set,
  input wire logic [31:0] ram_read_addr,
  input wire logic [31:0] ram_write_addr,
  input wire logic [NUM_SETS-1:0] first_id_enable,
  input wire logic [NUM_SETS-1:0] second_id_enable,
  input wire logic [NUM_SETS-1:0] word_transfer
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic go;
  logic ok;
  logic cw;
  logic wd;
  assign go = psel && penable && pready;
  assign ok = paddr[1:0] == 2'h0 && (paddr <= CMD_OFS || paddr[7:4] == 4'h1);
  assign cw = go && pwrite && ok && paddr[7:4] == 4'h1;
  assign wd = word_transfer[acc_set];
  //////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_acc(req);
    req && !go ##1 $stable(acc_set);
  endsequence
  property p_wait;
    s_setup |-> !pready ##1 pready;
  endproperty
  property p_err;
    pready |-> pslverr == !ok;
  endproperty
  property p_hold;
    $changed({first_id_enable, second_id_enable, word_transfer}) |-> $past(cw);
  endproperty
  property p_first;
    cw && paddr == CTRL0_OFS |=> first_id_enable[0] == $past(pwdata[7]);
  endproperty
  property p_second;
    cw && paddr == CTRL3_OFS |=> second_id_enable[3] == $past(pwdata[6]);
  endproperty
  property p_word;
    cw |=> word_transfer[$past(paddr[3:2])] == $past(pwdata[XFER_SIZE_BIT]);
  endproperty
  property p_rd_step;
    s_acc(acc_rd_req) |=> ram_read_addr < $past(ram_read_addr) ||
      ram_read_addr == $past(ram_read_addr) + ($past(wd, 2) ? 32'h2 : 32'h1);
  endproperty
  property p_wr_step;
    s_acc(acc_wr_req) |=> ram_write_addr < $past(ram_write_addr) ||
      ram_write_addr == $past(ram_write_addr) + ($past(wd, 2) ? 32'h2 : 32'h1);
  endproperty
  a_wait: assert property (p_wait) else $error("answer timing");
  a_err: assert property (p_err) else $error("error flag");
  a_hold: assert property (p_hold) else $error("control moved");
  a_first: assert property (p_first) else $error("first id");
  a_second: assert property (p_second) else $error("second id");
  a_word: assert property (p_word) else $error("size bit");
  a_rd_step: assert property (p_rd_step) else $error("read step");
  a_wr_step: assert property (p_wr_step) else $error("write step");
endmodule // ram_fifo_chk

bind ram_fifo_pointer_set_control ram_fifo_chk u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .acc_rd_req, .acc_wr_req, .acc_set, .ram_read_addr, .ram_write_addr,
  .first_id_enable, .second_id_enable, .word_transfer);
`default_nettype wire

// >>> verification/peri_model.sv
// Peripheral model: issues RAM read and write access pulses
`timescale 1ns/1ps
`default_nettype none
module peri_model (
  input wire logic pclk,
  output logic acc_rd_req,
  output logic acc_wr_req,
  output logic [1:0] acc_set
);
  initial begin
    acc_rd_req = 1'h0;
    acc_wr_req = 1'h0;
    acc_set = 2'h0;
  end
  // One access per edge, or one every other edge when slow
  task automatic burst(input logic rd, input logic [1:0] s, input int n,
    input logic slow);
    repeat (n) begin
      @(posedge pclk);
      acc_set <= s;
      acc_rd_req <= rd;
      acc_wr_req <= !rd;
      if (slow) begin
        @(posedge pclk);
        acc_rd_req <= 1'h0;
        acc_wr_req <= 1'h0;
      end
    end
    @(posedge pclk);
    acc_rd_req <= 1'h0;
    acc_wr_req <= 1'h0;
    acc_set <= ~s;
  endtask
endmodule // peri_model
`default_nettype wire

// >>> verification/ram_fifo_pointer_set_control_test.sv
// Testbench: register map, pointer and temporary pointer scenarios
`timescale 1ns/1ps
`default_nettype none
module ram_fifo_pointer_set_control_test
  import ram_fifo_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic acc_rd_req, acc_wr_req;
  logic [1:0] acc_set;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, ram_read_addr, ram_write_addr, d;
  logic [NUM_SETS-1:0] first_id_enable, second_id_enable, word_transfer;
  logic [33:0] notes[$];
  logic [33:0] n;
  logic [2:0] it;
  int mismatches = 0;
  int tests_run = 0;
  integer seed = 32'hDB430C29;
  logic [31:0] rst_val [8] = '{32'hFFF00000, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h7FF, 32'hFFF00000, 32'hFFF00000};

  ram_fifo_pointer_set_control DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .acc_rd_req,
    .acc_wr_req, .acc_set, .ram_read_addr, .ram_write_addr,
    .first_id_enable, .second_id_enable, .word_transfer);
  peri_model peri (.pclk, .acc_rd_req, .acc_wr_req, .acc_set);

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", w, e, g);
      mismatches++;
    end
  endtask
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] v,
    logic [33:0] note);
    int k;
    @(posedge pclk);
    notes.push_back(note);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20 && pready !== 1'h1; k++) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 20) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'h1, a, v, 34'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, {2'h1, e});
  endtask
  task automatic wi(input logic [1:0] s, logic [2:0] i, logic [31:0] v);
    wr(VIEW_OFS, {26'h0, s, 1'h0, i});
    if (i < 4) wr(WINDOW_OFS, v);
  endtask
  task automatic ri(input logic [1:0] s, logic [2:0] i, logic [31:0] e);
    wi(s, i | 3'h4, 32'h0);
    wr(VIEW_OFS, {26'h0, s, 1'h0, i});
    rd(WINDOW_OFS, e);
  endtask

  always @(posedge pclk) begin
    if (presetn === 1'h1 && pready === 1'h1) begin
      n = notes.pop_front();
      check("pslverr", {31'h0, n[33]}, {31'h0, pslverr});
      if (n[32]) check("prdata", n[31:0], prdata);
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 4; i++) rd(CTRL0_OFS + 8'(4 * i), 32'h06);
    for (int i = 0; i < 8; i++) ri(2'h0, 3'(i), rst_val[i]);
    $display("Test reset done");
    wr(8'h14, 32'h0);
    wi(2'h1, ITEM_BASE, 32'h00012340);
    ri(2'h1, ITEM_BASE, 32'hFFF12340);
    peri.burst(1'h0, 2'h1, 3, 1'h1);
    peri.burst(1'h1, 2'h1, 1, 1'h0);
    ri(2'h1, ITEM_VALID, 32'h2);
    ri(2'h1, ITEM_FREE, 32'h1E);
    ri(2'h1, ITEM_READ_START, 32'hFFF12341);
    ri(2'h1, ITEM_WRITE_START, 32'hFFF12343);
    peri.burst(1'h1, 2'h2, 1, 1'h1);
    repeat (2) @(posedge pclk);
    check("read addr", 32'hFFF12341, ram_read_addr);
    check("write addr", 32'hFFF12343, ram_write_addr);
    wi(2'h1, ITEM_WRITE_PTR, 32'h7FF);
    ri(2'h1, ITEM_WRITE_PTR, 32'h1F);
    peri.burst(1'h0, 2'h1, 1, 1'h0);
    ri(2'h1, ITEM_WRITE_PTR, 32'h0);
    wr(8'h14, 32'h0F);
    peri.burst(1'h0, 2'h1, 2, 1'h1);
    ri(2'h1, ITEM_WRITE_PTR, 32'h4);
    ri(2'h1, ITEM_VALID, 32'h3);
    $display("Test pointers done");
    for (int m = 2; m < 4; m++) begin
      it = (m == 3) ? ITEM_READ_PTR : ITEM_WRITE_PTR;
      wr(8'h14, {26'h0, 2'(m), 4'h6});
      wi(2'h1, it, 32'(8 * m));
      wr(CMD_OFS, 32'h14);
      ri(2'h1, ITEM_TEMP, 32'(8 * m));
      peri.burst(1'(m == 3), 2'h1, 2, 1'h1);
      wr(CMD_OFS, 32'h18);
      ri(2'h1, it, 32'(8 * m));
    end
    wr(8'h14, 32'h06);
    wi(2'h1, ITEM_TEMP, 32'h20);
    wr(CMD_OFS, 32'h14);
    ri(2'h1, ITEM_TEMP, 32'h20);
    wr(CMD_OFS, 32'h12);
    ri(2'h1, ITEM_TEMP, 32'h0);
    ri(2'h1, ITEM_READ_PTR, 32'h0);
    $display("Test temporary pointer done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(CTRL0_OFS + 8'(4 * i), d);
      rd(CTRL0_OFS + 8'(4 * i), {24'h0, d[7:0]});
      check("first id", {31'h0, d[7]}, {31'h0, first_id_enable[i]});
      check("second id", {31'h0, d[6]}, {31'h0, second_id_enable[i]});
      check("word", {31'h0, d[3]}, {31'h0, word_transfer[i]});
    end
    apb(1'h0, 8'h0C, 32'h0, {2'h3, 32'h0});
    apb(1'h1, 8'h20, d, {2'h2, 32'h0});
    $display("Test control and map done");
    give_verdict();
  end
endmodule // ram_fifo_pointer_set_control_test
`default_nettype wire
